// file: verilog/fault_supervisor.sv
// fault supervisor: state machine, sticky flags, interrupt pin
// assumes analog levels on ana_raw, other inputs from clk-domain logic
//
// Functional notes
// - held low 20 ms: channel off, test current
// - low after test window reports ground short
// - ground short: all power off, fault recovery
// - summary, reason, channel bits; details persist
// - live unused output at init flags, interrupts
// - config resistors sampled only at init
// - stalled i2c 500 ms: reset, flag, interrupt
// - input undervoltage: flag, standby until clear
// - input overvoltage: flag, standby until clear
// - regulator undervoltage: flag, restart, no recovery
// - overcurrent or pump level: recovery, 100 ms
// - pump parts missing: pump off, keep running
// - lost sync clock: internal clock, spread by pin
// - trim check error at load: flag, interrupt
// - boost overvolt low: flag, stop switching only
// - boost overvolt high: recovery until voltage falls
// - feedback under 110 ms: overcurrent, recovery
// - channel resistor bad: flag, four channels 200mA
// - mode resistor bad: phase shift, address 0x3A
// - frequency resistor bad: 400 kHz, 305 Hz
// - recovery holds outputs off 100 ms
// - all strings faulted latches until enable low
`timescale 1ns/100ps
module fault_supervisor
    import fault_pkg::*;
#(
    parameter int unsigned SHORT_HOLD_CYC  = SHORT_HOLD_CYCLES,
    parameter int unsigned TEST_WINDOW_CYC = TEST_WINDOW_CYCLES,
    parameter int unsigned I2C_STALL_CYC   = I2C_STALL_CYCLES,
    parameter int unsigned RECOVERY_CYC    = RECOVERY_CYCLES,
    parameter int unsigned FB_UV_HOLD_CYC  = FB_UV_HOLD_CYCLES
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire ana_s         ana_raw,
    input  wire logic         init_done,
    input  wire logic         crc_fail,
    input  wire logic         channel_cfg_resistor_bad,
    input  wire logic         mode_bad,
    input  wire logic         fset_bad,
    input  wire cfg_s         det_cfg,
    input  wire logic [3:0]   chan_used,
    input  wire logic [3:0]   string_off,
    input  wire logic         brightness_nz,
    input  wire logic         boost_ready,
    input  wire logic         i2c_open,
    input  wire logic         int_clear,
    output logic              boost_en_q,
    output logic              pl_fet_en_q,
    output logic [3:0]        led_en_q,
    output logic [3:0]        test_src_q,
    output logic              boost_hold_q,
    output logic              pump_off_q,
    output logic              i2c_reset_q,
    output logic              int_n_q,
    output logic              int_clk_sel_q,
    output logic              spread_en_q,
    output cfg_s              cfg_q,
    output fault_flags_s      flags_q
);
    ana_s         ana;
    state_e       state_q, state_d;
    fault_flags_s set_v, flags_d;
    cfg_s         cfg_pick;
    logic [3:0]   hold_done, test_mask_d, gnd_hit, led_en_d;
    logic         in_run, run_d, test_act, test_start, win_done;
    logic         gnd_event, i2c_done, i2c_done_q, i2c_stall, fbuv_done;
    logic         rec_done, ovph, stby_fault, rec_fault, all_off;
    logic         init_cap, mon, pending, sync_armed_q, sync_lost;
    logic         run_start;

    sync2 #(.W($bits(ana_s))) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (ana_raw),
        .q       (ana)
    );

    assign in_run = (state_q == ST_BOOST_SU) || (state_q == ST_NORMAL);
    assign run_d  = (state_d == ST_BOOST_SU) || (state_d == ST_NORMAL);
    assign mon    = (state_q != ST_INIT);

    // ground short screening, one hold timer per channel
    for (genvar g = 0; g < 4; g++) begin : g_hold
        hold_timer #(.CYCLES(SHORT_HOLD_CYC)) u_hold (
            .clk     (clk),
            .reset_n (reset_n),
            .run     (in_run && chan_used[g] && ana.led_below_gnd[g]
                      && !test_act),
            .done    (hold_done[g])
        );
    end

    // one shared test window; channels found together are tested together
    hold_timer #(.CYCLES(TEST_WINDOW_CYC)) u_win (
        .clk     (clk),
        .reset_n (reset_n),
        .run     (test_act),
        .done    (win_done)
    );

    assign test_act   = |test_src_q;
    assign test_start = in_run && !test_act && (|hold_done);
    assign gnd_hit    = test_src_q & ana.led_below_hr;
    assign gnd_event  = win_done && (|gnd_hit);
    assign test_mask_d = !in_run    ? 4'h0 :
                         test_start ? hold_done :
                         win_done   ? 4'h0 : test_src_q;
    // a stalled transaction must be released exactly once
    hold_timer #(.CYCLES(I2C_STALL_CYC)) u_i2c (
        .clk     (clk),
        .reset_n (reset_n),
        .run     (i2c_open),
        .done    (i2c_done)
    );
    assign i2c_stall = i2c_done && !i2c_done_q;
    hold_timer #(.CYCLES(FB_UV_HOLD_CYC)) u_fbuv (
        .clk     (clk),
        .reset_n (reset_n),
        .run     (in_run && ana.fb_uv),
        .done    (fbuv_done)
    );
    hold_timer #(.CYCLES(RECOVERY_CYC)) u_rec (
        .clk     (clk),
        .reset_n (reset_n),
        .run     (state_q == ST_RECOVERY),
        .done    (rec_done)
    );
    assign ovph       = ana.ovph_fb || ana.ovph_dis;
    assign stby_fault = ana.in_uv || ana.in_ov || ana.reg_uv;
    // a missing pump part alone must not force recovery
    assign rec_fault  = ana.in_oc || (ana.pump_bad && !ana.pump_missing)
                        || ovph || fbuv_done || gnd_event;
    assign all_off    = ((chan_used & ~string_off) == 4'h0) && (|chan_used);
    assign run_start  = (state_q == ST_STANDBY) && run_d;
    assign sync_lost  = sync_armed_q && !ana.sync_ok;
    assign init_cap   = (state_q == ST_INIT) && init_done;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_INIT: begin
                if (init_done) begin
                    state_d = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (ana.enable && brightness_nz && !stby_fault) begin
                    state_d = ST_BOOST_SU;
                end
            end
            ST_BOOST_SU, ST_NORMAL: begin
                if (stby_fault) begin
                    state_d = ST_STANDBY;
                end else if (rec_fault) begin
                    state_d = ST_RECOVERY;
                end else if (all_off) begin
                    state_d = ST_LATCH;
                end else if (!ana.enable) begin
                    state_d = ST_STANDBY;
                end else if (state_q == ST_BOOST_SU && boost_ready) begin
                    state_d = ST_NORMAL;
                end
            end
            ST_RECOVERY: begin
                if (rec_done && !ovph) begin
                    state_d = ST_STANDBY;
                end
            end
            ST_LATCH: begin
                if (!ana.enable) begin
                    state_d = ST_STANDBY;
                end
            end
            default: begin
                state_d = ST_INIT;
            end
        endcase
    end

    always_comb begin
        set_v = '0;
        set_v.ground_short_reason_bit     = gnd_event;
        set_v.channel_fault_bits          = gnd_event ? gnd_hit : 4'h0;
        set_v.led_fault_summary_flag      = gnd_event;
        set_v.unused_string_error_flag    =
            init_cap && (|(~chan_used & ana.unused_live));
        set_v.i2c_error_flag              = i2c_stall;
        set_v.input_undervoltage_flag     = mon && ana.in_uv;
        set_v.input_overvoltage_flag      = mon && ana.in_ov;
        set_v.regulator_undervoltage_flag = mon && ana.reg_uv;
        set_v.input_overcurrent_flag      = in_run && ana.in_oc;
        set_v.pump_level_fault_flag       =
            mon && (ana.pump_bad || ana.pump_missing);
        set_v.pump_parts_missing_flag     = mon && ana.pump_missing;
        set_v.sync_clock_lost_flag        = sync_lost;
        set_v.trim_check_error_flag       = init_cap && crc_fail;
        set_v.boost_overvolt_low_flag     = in_run && ana.ovp_low;
        set_v.boost_overvolt_high_flag    = in_run && ovph;
        set_v.boost_overcurrent_flag      = fbuv_done;
        set_v.channel_cfg_resistor_flag   = init_cap && channel_cfg_resistor_bad;
        set_v.mode_resistor_flag          = init_cap && mode_bad;
        set_v.freq_resistor_flag          = init_cap && fset_bad;
    end

    // set wins over a clear in the same cycle
    assign flags_d = fault_flags_s'((int_clear ? (flags_q & DETAIL_KEEP)
                                               : flags_q) | set_v);
    assign pending = |(flags_q & INT_RAISE);

    always_comb begin
        cfg_pick = det_cfg;
        if (channel_cfg_resistor_bad) begin
            cfg_pick.ch_count = DEFAULT_CFG.ch_count;
            cfg_pick.ch_ma    = DEFAULT_CFG.ch_ma;
        end
        if (mode_bad) begin
            cfg_pick.phase_shift = DEFAULT_CFG.phase_shift;
            cfg_pick.i2c_addr    = DEFAULT_CFG.i2c_addr;
        end
        if (fset_bad) begin
            cfg_pick.boost_khz = DEFAULT_CFG.boost_khz;
            cfg_pick.pwm_hz    = DEFAULT_CFG.pwm_hz;
        end
    end

    assign led_en_d = (state_d == ST_NORMAL && brightness_nz) ?
                      (chan_used & ~string_off & ~test_mask_d) : 4'h0;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q    <= ST_INIT;
            flags_q    <= '0;
            test_src_q <= 4'h0;
            i2c_done_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            flags_q    <= flags_d;
            test_src_q <= test_mask_d;
            i2c_done_q <= i2c_done;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            boost_en_q   <= 1'b0;
            pl_fet_en_q  <= 1'b0;
            led_en_q     <= 4'h0;
            boost_hold_q <= 1'b0;
            i2c_reset_q  <= 1'b0;
            int_n_q      <= 1'b1;
            pump_off_q   <= 1'b0;
        end else begin
            boost_en_q   <= run_d;
            pl_fet_en_q  <= run_d;
            led_en_q     <= led_en_d;
            boost_hold_q <= run_d && ana.ovp_low;
            i2c_reset_q  <= i2c_stall;
            int_n_q      <= !pending;
            pump_off_q   <= pump_off_q || (mon && ana.pump_missing);
        end
    end

    // configuration is frozen after init; later resistor loss is ignored
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q <= DEFAULT_CFG;
        end else if (init_cap) begin
            cfg_q <= cfg_pick;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_armed_q  <= 1'b0;
            int_clk_sel_q <= 1'b1;
            spread_en_q   <= 1'b0;
        end else begin
            if (run_start) begin
                sync_armed_q  <= ana.sync_ok;
                int_clk_sel_q <= !ana.sync_ok;
            end else if (sync_lost) begin
                sync_armed_q  <= 1'b0;
                int_clk_sel_q <= 1'b1;
            end
            spread_en_q <= (int_clk_sel_q || sync_lost) && ana.sync_high;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_enter_rec;
        $rose(state_q == ST_RECOVERY);
    endsequence
    sequence s_power_off;
        (!boost_en_q && !pl_fet_en_q && led_en_q == 4'h0)[*8];
    endsequence
    test_ch_off_a: assert property (
        (led_en_q & test_src_q) == 4'h0)
        else $error("led enabled while under ground test");
    gnd_report_a: assert property (
        gnd_event |=> flags_q.ground_short_reason_bit
                      && flags_q.led_fault_summary_flag)
        else $error("ground short not reported");
    gnd_power_off_a: assert property (
        gnd_event |=> state_q == ST_RECOVERY && !boost_en_q && !pl_fet_en_q)
        else $error("ground short left power on");
    detail_persist_a: assert property (
        flags_q.ground_short_reason_bit |=> flags_q.ground_short_reason_bit)
        else $error("ground short detail bit lost");
    cfg_frozen_a: assert property (
        state_q != ST_INIT |=> $stable(cfg_q))
        else $error("configuration changed after init");
    i2c_release_a: assert property (
        i2c_stall |=> i2c_reset_q && flags_q.i2c_error_flag)
        else $error("stalled i2c not released");
    uv_standby_a: assert property (
        in_run && ana.in_uv |=> state_q == ST_STANDBY)
        else $error("undervoltage did not drop to standby");
    ov_hold_a: assert property (
        state_q == ST_STANDBY && ana.in_ov |=> state_q == ST_STANDBY)
        else $error("restart during overvoltage");
    rec_hold_a: assert property (
        s_enter_rec |-> s_power_off)
        else $error("outputs on early in recovery");
    latch_hold_a: assert property (
        state_q == ST_LATCH && ana.enable |=> state_q == ST_LATCH)
        else $error("latched fault left with enable high");
    int_pin_a: assert property (
        pending |=> !int_n_q)
        else $error("interrupt pin idle with flag pending");
endmodule

// file: verilog/fault_pkg.sv
// shared types and constants for the led driver fault supervisor
// assumes one 40 MHz clock; analog comparators arrive as raw levels
package fault_pkg;

    localparam int unsigned CLK_HZ     = 40_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;

    localparam int unsigned SHORT_HOLD_MS  = 20;
    localparam int unsigned TEST_WINDOW_US = 300;
    localparam int unsigned I2C_STALL_MS   = 500;
    localparam int unsigned RECOVERY_MS    = 100;
    localparam int unsigned FB_UV_HOLD_MS  = 110;

    localparam int unsigned SHORT_HOLD_CYCLES  = SHORT_HOLD_MS * CYC_PER_MS;
    localparam int unsigned TEST_WINDOW_CYCLES = TEST_WINDOW_US * CYC_PER_US;
    localparam int unsigned I2C_STALL_CYCLES   = I2C_STALL_MS * CYC_PER_MS;
    localparam int unsigned RECOVERY_CYCLES    = RECOVERY_MS * CYC_PER_MS;
    localparam int unsigned FB_UV_HOLD_CYCLES  = FB_UV_HOLD_MS * CYC_PER_MS;

    // comparator and pin levels, all outside the clock domain
    typedef struct packed {
        logic       enable;
        logic [3:0] led_below_gnd;
        logic [3:0] led_below_hr;
        logic [3:0] unused_live;
        logic       in_uv;
        logic       in_ov;
        logic       reg_uv;
        logic       in_oc;
        logic       pump_bad;
        logic       pump_missing;
        logic       sync_ok;
        logic       sync_high;
        logic       ovp_low;
        logic       ovph_fb;
        logic       ovph_dis;
        logic       fb_uv;
    } ana_s;

    typedef struct packed {
        logic [2:0]  ch_count;
        logic [7:0]  ch_ma;
        logic        phase_shift;
        logic [6:0]  i2c_addr;
        logic [11:0] boost_khz;
        logic [11:0] pwm_hz;
    } cfg_s;

    localparam cfg_s DEFAULT_CFG = '{
        ch_count:    3'h4,
        ch_ma:       8'hC8,
        phase_shift: 1'h1,
        i2c_addr:    7'h3A,
        boost_khz:   12'h190,
        pwm_hz:      12'h131
    };

    typedef struct packed {
        logic       ground_short_reason_bit;
        logic [3:0] channel_fault_bits;
        logic       led_fault_summary_flag;
        logic       unused_string_error_flag;
        logic       i2c_error_flag;
        logic       input_undervoltage_flag;
        logic       input_overvoltage_flag;
        logic       regulator_undervoltage_flag;
        logic       input_overcurrent_flag;
        logic       pump_level_fault_flag;
        logic       pump_parts_missing_flag;
        logic       sync_clock_lost_flag;
        logic       trim_check_error_flag;
        logic       boost_overvolt_low_flag;
        logic       boost_overvolt_high_flag;
        logic       boost_overcurrent_flag;
        logic       channel_cfg_resistor_flag;
        logic       mode_resistor_flag;
        logic       freq_resistor_flag;
    } fault_flags_s;

    // detail bits survive the interrupt clear
    localparam fault_flags_s DETAIL_KEEP = '{
        ground_short_reason_bit: 1'h1,
        channel_fault_bits:      4'hF,
        default:                 1'h0
    };

    localparam fault_flags_s INT_RAISE = '{
        ground_short_reason_bit:   1'h0,
        channel_fault_bits:        4'h0,
        boost_overvolt_low_flag:   1'h0,
        channel_cfg_resistor_flag: 1'h0,
        mode_resistor_flag:        1'h0,
        freq_resistor_flag:        1'h0,
        default:                   1'h1
    };

    typedef enum logic [2:0] {
        ST_INIT,
        ST_STANDBY,
        ST_BOOST_SU,
        ST_NORMAL,
        ST_RECOVERY,
        ST_LATCH
    } state_e;

endpackage

// file: verilog/sync2.sv
// two flip-flop synchroniser for a group of levels
// assumes each bit is a slow level; no bus coherence across bits
`timescale 1ns/100ps
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// file: verilog/hold_timer.sv
// counts cycles while run is high; done once CYCLES have elapsed
// assumes run from the same clock; dropping run restarts the count
`timescale 1ns/100ps
module hold_timer #(
    parameter int unsigned CYCLES = 1
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic run,
    output logic      done
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] cnt_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
        end else if (!run) begin
            cnt_q <= '0;
        end else if (cnt_q != W'(CYCLES)) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign done = run && (cnt_q == W'(CYCLES));
endmodule

// file: tb/host_model.sv
// host side model: opens i2c transactions and clears interrupts
// assumes int_n_q active low; clears once the pin stood low a while
`timescale 1ns/100ps
module host_model (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic int_n_q,
    input  wire logic stall_req,
    output logic      i2c_open,
    output logic      int_clear
);
    logic [3:0] low_q;

    // a stalled transaction is a plain level, never closed by stop
    assign i2c_open = stall_req;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            low_q     <= 4'h0;
            int_clear <= 1'h0;
        end else begin
            // slow reaction so the bench sees the pin low first
            low_q     <= int_n_q ? 4'h0 : low_q + 4'h1;
            int_clear <= (low_q == 4'h6);
        end
    end
endmodule

// file: tb/fault_supervisor_test.sv
// self-checking bench for the fault supervisor with a host model
// assumes shortened counts; channels 0..2 used, channel 3 unused
`timescale 1ns/100ps
module fault_supervisor_test;
    import fault_pkg::*;
    typedef struct packed {
        fault_flags_s f;
        logic         irq;
    } note_s;
    logic clk, reset_n, init_done, crc_fail, channel_cfg_resistor_bad, mode_bad, fset_bad;
    logic brightness_nz, boost_ready, stall_req, i2c_open, int_clear;
    logic boost_en_q, pl_fet_en_q, boost_hold_q, pump_off_q, i2c_reset_q;
    logic int_n_q, int_clk_sel_q, spread_en_q;
    logic [3:0] chan_used, string_off, led_en_q, test_src_q, ch;
    ana_s         ana;
    cfg_s         det_cfg, cfg_q;
    fault_flags_s flags_q, prev, nw;
    note_s        n;
    note_s        exp_q[$];
    int errors, samples_checked, cyc, pulses;

    fault_supervisor #(.SHORT_HOLD_CYC(20), .TEST_WINDOW_CYC(10),
        .I2C_STALL_CYC(30), .RECOVERY_CYC(12), .FB_UV_HOLD_CYC(25)) u_dut (
        .clk, .reset_n, .ana_raw(ana), .init_done, .crc_fail, .channel_cfg_resistor_bad,
        .mode_bad, .fset_bad, .det_cfg, .chan_used, .string_off,
        .brightness_nz, .boost_ready, .i2c_open, .int_clear, .boost_en_q,
        .pl_fet_en_q, .led_en_q, .test_src_q, .boost_hold_q, .pump_off_q,
        .i2c_reset_q, .int_n_q, .int_clk_sel_q, .spread_en_q, .cfg_q,
        .flags_q);
    host_model u_host (.clk, .reset_n, .int_n_q, .stall_req, .i2c_open,
        .int_clear);

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    task automatic chk(input logic [63:0] got, exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h", $time, what, got);
        end
    endtask

    task automatic note(input fault_flags_s f, input logic irq);
        exp_q.push_back('{f, irq});
    endtask

    task automatic end_sim;
        $display("counts: %0d checked, %0d errors", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // one fault cause pulsed; kind 2 powers down, 1 keeps running, 0 quiet
    task automatic inject(input int ai, input logic [21:0] fm, input int kind);
        note(fm, kind != 0);
        @(posedge clk);
        ana <= ana | ana_s'(25'h1 << ai);
        repeat (ai == 0 ? 34 : 4) @(posedge clk);
        @(negedge clk);
        if (kind == 2) chk(boost_en_q, 1'h0, "power off");
        else chk(led_en_q, 4'h7, "leds run");
        if (kind == 0) chk(boost_hold_q, 1'h1, "boost hold");
        @(posedge clk);
        ana <= ana & ~ana_s'(25'h1 << ai);
        repeat (60) @(posedge clk);
        @(negedge clk);
        chk(boost_en_q, 1'h1, "restart");
        chk(int_n_q, 1'h1, "int clear");
    endtask

    // each newly raised flag group is matched to the oldest note
    initial begin
        prev = '0;
        forever begin
            @(negedge clk);
            nw = flags_q & ~prev;
            prev = flags_q;
            if (reset_n && nw != '0) begin
                if (exp_q.size() == 0) begin
                    errors++;
                    $display("unexpected at %0t: stray flags %h", $time, nw);
                end else begin
                    n = exp_q.pop_front();
                    chk(nw, n.f, "new flags");
                    @(negedge clk);
                    chk(int_n_q, !n.irq, "int pin");
                    prev = flags_q;
                end
            end
        end
    end

    always @(negedge clk) if (i2c_reset_q === 1'b1) pulses++;

    // run needs about 1020 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            errors++;
            $display("unexpected at %0t: timeout", $time);
            end_sim();
        end
    end

    initial begin
        void'($urandom(32'h512C));
        reset_n = 1'b0;
        init_done = 1'b0;
        {crc_fail, channel_cfg_resistor_bad, mode_bad, fset_bad} = 4'hF;
        {brightness_nz, boost_ready, stall_req} = 3'h6;
        chan_used = 4'h7;
        string_off = 4'h0;
        det_cfg = cfg_s'(43'({$urandom, $urandom}));
        ana = '0;
        ana.enable = 1'h1;
        ana.unused_live = 4'h8;
        ana.sync_ok = 1'h1;
        ana.sync_high = 1'h1;
        note(22'h008047, 1'h1);
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        // pin levels need two edges through the synchroniser first
        repeat (3) @(posedge clk);
        init_done <= 1'b1;
        repeat (40) @(posedge clk);
        {crc_fail, channel_cfg_resistor_bad, mode_bad, fset_bad} <= 4'h0;
        det_cfg <= cfg_s'(43'({$urandom, $urandom}));
        @(negedge clk);
        chk(cfg_q, DEFAULT_CFG, "defaults");
        chk(led_en_q, 4'h7, "running");
        $display("test init done");

        ch = 4'h1 << ($urandom % 3);
        note({1'h1, ch, 17'h10000}, 1'h1);
        @(posedge clk);
        ana.led_below_gnd <= ch;
        ana.led_below_hr <= ch;
        repeat (26) @(posedge clk);
        @(negedge clk);
        chk(test_src_q, ch, "test current");
        chk(led_en_q, 4'h7 & ~ch, "channel off");
        repeat (14) @(posedge clk);
        @(negedge clk);
        chk({boost_en_q, pl_fet_en_q, led_en_q}, 6'h0, "all off");
        @(posedge clk);
        ana.led_below_gnd <= 4'h0;
        ana.led_below_hr <= 4'h0;
        repeat (70) @(posedge clk);
        @(negedge clk);
        chk(flags_q[21:16], {1'h1, ch, 1'h0}, "details kept");
        chk(boost_en_q, 1'h1, "restart");
        @(posedge clk);
        ana.led_below_gnd <= ch;
        repeat (40) @(posedge clk);
        ana.led_below_gnd <= 4'h0;
        repeat (15) @(posedge clk);
        @(negedge clk);
        chk(boost_en_q, 1'h1, "no short");
        $display("test ground short done");

        inject(8, 22'h000400, 2);
        inject(7, 22'h000200, 2);
        inject(11, 22'h002000, 2);
        inject(10, 22'h001000, 2);
        inject(9, 22'h000800, 2);
        inject(2, 22'h000010, 2);
        inject(1, 22'h000010, 2);
        inject(0, 22'h000008, 2);
        inject(3, 22'h000020, 0);
        inject(6, 22'h000300, 1);
        chk(pump_off_q, 1'h1, "pump off");
        $display("test fault table done");

        note(22'h004000, 1'h1);
        stall_req <= 1'b1;
        repeat (45) @(posedge clk);
        stall_req <= 1'b0;
        repeat (20) @(posedge clk);
        chk(pulses, 1, "i2c reset pulses");
        $display("test i2c stall done");

        note(22'h000080, 1'h1);
        ana.sync_ok <= 1'h0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk({int_clk_sel_q, spread_en_q, boost_en_q}, 3'h7, "sync lost");
        $display("test sync loss done");

        string_off <= 4'h7;
        repeat (6) @(posedge clk);
        ana.enable <= 1'h0;
        @(negedge clk);
        chk(boost_en_q, 1'h0, "latched");
        repeat (6) @(posedge clk);
        string_off <= 4'h0;
        ana.enable <= 1'h1;
        repeat (30) @(posedge clk);
        @(negedge clk);
        chk(boost_en_q, 1'h1, "unlatched");
        chk(cfg_q, DEFAULT_CFG, "frozen cfg");
        chk(exp_q.size(), 0, "notes left");
        $display("test latch done");
        end_sim();
    end
endmodule
